// ===== include/sfr_regs.svh
`ifndef SFR_REGS_SVH
`define SFR_REGS_SVH
`define SFR_CLK_MHZ          10
`define SFR_LOW_PULSE_US     10
`define SFR_SELECT_WAIT_US   10
`define SFR_DECODE_US        40
`define SFR_READ_US          35
`define SFR_PROGRAM_US       310
`define SFR_SECTOR_MS        12
`define SFR_BLOCK_MS         25
`define SFR_CHIP_MS          100
`define SFR_STATUS_MS        40
`define SFR_SETTLE_US        100
`define SFR_US_TO_CYC(t)     ((t) * `SFR_CLK_MHZ)
`define SFR_MS_TO_CYC(t)     ((t) * 1000 * `SFR_CLK_MHZ)
`define SFR_LOCK_DEFAULT     1'b1
`endif

// ===== include/sfr_pkg.sv
package sfr_pkg;
    typedef enum logic [3:0] {
        SFR_OP_IDLE    = 4'h0,
        SFR_OP_DECODE  = 4'h1,
        SFR_OP_READ    = 4'h2,
        SFR_OP_PROGRAM = 4'h3,
        SFR_OP_SECTOR  = 4'h4,
        SFR_OP_BLOCK   = 4'h5,
        SFR_OP_CHIP    = 4'h6,
        SFR_OP_STATUS  = 4'h7
    } sfr_op_e;
    typedef enum logic [4:0] {
        SFR_ST_POR     = 5'h01,
        SFR_ST_RESET   = 5'h02,
        SFR_ST_RECOVER = 5'h04,
        SFR_ST_READONLY = 5'h08,
        SFR_ST_READY   = 5'h10
    } sfr_state_e;
    typedef struct packed {
        logic write_enable_latch;
        logic write_in_progress;
        logic block_lock;
    } sfr_vol_s;
    typedef struct packed {
        logic ready;
        logic write_ok;
        logic pulse_short;
    } sfr_stat_s;
endpackage

// ===== src/sfr_timer.sv
`timescale 1ns/1ps
module sfr_timer #(
    parameter int W = 24
) (
    // Clock and reset.
    input  wire logic         ref_clk_in,
    input  wire logic         arst_n_in,
    // Control.
    input  wire logic         load_in,
    input  wire logic [W-1:0] value_in,
    // Status.
    output logic              done_out
);
    logic [W-1:0] count;
    wire  logic   zero = (count == '0);
    wire  logic [W-1:0] next_count = load_in ? value_in :
                                     (zero ? count : count - 1'b1);
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            count <= '0;
            done_out <= 1'b0;
        end else begin
            count <= next_count;
            done_out <= !load_in && (next_count == '0);
        end
    end
endmodule // sfr_timer

// ===== src/sfr_reset_seq.sv
`timescale 1ns/1ps
`include "sfr_regs.svh"
// Contract
// - After a reset cycle the device sits in standby, ready to be selected.
// - Reset returns the enable latch, busy flag and lock bits to defaults.
// - Reset during a program or erase aborts that operation at once.
// - While reset is low the data output is high impedance, activity low.
// - Ready within 40, 35 or 310 us after decode, read or program reset.
// - Recovery is 12, 25, 100 or 40 ms after sector, block, chip, status.
// - At power-up the device enters standby with the enable latch clear.
// - Reads are accepted once supply is valid and settling has elapsed; the code accepts reads already during settling (READONLY).
// - While power-on clear is active logic is held and commands ignored.
module sfr_reset_seq #(
    parameter int W              = 24,
    parameter int LOW_PULSE_CYC  = `SFR_US_TO_CYC(`SFR_LOW_PULSE_US),
    parameter int SETTLE_CYC     = `SFR_US_TO_CYC(`SFR_SETTLE_US),
    parameter int DECODE_CYC     = `SFR_US_TO_CYC(`SFR_DECODE_US),
    parameter int READ_CYC       = `SFR_US_TO_CYC(`SFR_READ_US),
    parameter int PROGRAM_CYC    = `SFR_US_TO_CYC(`SFR_PROGRAM_US),
    parameter int SECTOR_CYC     = `SFR_MS_TO_CYC(`SFR_SECTOR_MS),
    parameter int BLOCK_CYC      = `SFR_MS_TO_CYC(`SFR_BLOCK_MS),
    parameter int CHIP_CYC       = `SFR_MS_TO_CYC(`SFR_CHIP_MS),
    parameter int STATUS_CYC     = `SFR_MS_TO_CYC(`SFR_STATUS_MS)
) (
    // Clock and power-on clear.
    input  wire logic              ref_clk_in,
    input  wire logic              arst_n_in,
    // Supply and host pins.
    input  wire logic              supply_ok_in,
    input  wire logic              pin_reset_n_in,
    input  wire logic              select_n_in,
    // Core operation in progress.
    input  wire sfr_pkg::sfr_op_e  op_in,
    input  wire logic              wel_set_in,
    input  wire logic              wel_clr_in,
    input  wire logic              lock_set_in,
    // Outputs toward the core.
    output logic                   cmd_accept_out,
    output logic                   write_accept_out,
    output logic                   abort_out,
    output logic                   data_oe_out,
    output logic                   standby_out,
    output sfr_pkg::sfr_vol_s      vol_out,
    output sfr_pkg::sfr_stat_s     stat_out
);
    sfr_pkg::sfr_state_e state;
    sfr_pkg::sfr_op_e    op_at_reset;
    logic [W-1:0]        low_count;
    logic                pulse_valid;
    logic                timer_done;
    logic                pin_low_q;

    wire logic pin_low   = !pin_reset_n_in;
    wire logic pin_rise  = pin_low_q && !pin_low;
    wire logic pulse_long = (low_count >= W'(LOW_PULSE_CYC));
    // Only a program, an erase or a status write is an operation to abort.
    wire logic busy_op   = (op_in == sfr_pkg::SFR_OP_PROGRAM) ||
                           (op_in == sfr_pkg::SFR_OP_SECTOR) ||
                           (op_in == sfr_pkg::SFR_OP_BLOCK) ||
                           (op_in == sfr_pkg::SFR_OP_CHIP) ||
                           (op_in == sfr_pkg::SFR_OP_STATUS);
    // A pulse of exactly the minimum width counts, so test the new count.
    wire logic [W-1:0] next_low_count = pin_low ?
        (pulse_long ? low_count : low_count + 1'b1) : '0;

    // Recovery length chosen by the operation that the reset hit.
    logic [W-1:0] recover_cyc;
    always_comb begin
        recover_cyc = W'(READ_CYC);
        unique case (op_at_reset)
            sfr_pkg::SFR_OP_DECODE:  recover_cyc = W'(DECODE_CYC);
            sfr_pkg::SFR_OP_PROGRAM: recover_cyc = W'(PROGRAM_CYC);
            sfr_pkg::SFR_OP_SECTOR:  recover_cyc = W'(SECTOR_CYC);
            sfr_pkg::SFR_OP_BLOCK:   recover_cyc = W'(BLOCK_CYC);
            sfr_pkg::SFR_OP_CHIP:    recover_cyc = W'(CHIP_CYC);
            sfr_pkg::SFR_OP_STATUS:  recover_cyc = W'(STATUS_CYC);
            default:                 recover_cyc = W'(READ_CYC);
        endcase
    end

    wire logic enter_settle = (state == sfr_pkg::SFR_ST_POR) && supply_ok_in;
    wire logic enter_recover = (state == sfr_pkg::SFR_ST_RESET) && pin_rise &&
                               pulse_valid;
    wire logic timer_load = enter_settle || enter_recover;
    wire logic [W-1:0] timer_value = enter_settle ? W'(SETTLE_CYC)
                                                  : recover_cyc;

    sfr_timer #(.W(W)) u_timer (
        .ref_clk_in (ref_clk_in),
        .arst_n_in  (arst_n_in),
        .load_in    (timer_load),
        .value_in   (timer_value),
        .done_out   (timer_done)
    );

    // Next state; supply loss wins, then a low reset pin overrides every state but POR.
    sfr_pkg::sfr_state_e next_state;
    always_comb begin
        next_state = state;
        unique case (state)
            sfr_pkg::SFR_ST_POR:
                if (supply_ok_in) next_state = sfr_pkg::SFR_ST_READONLY;
            sfr_pkg::SFR_ST_RESET:
                if (pin_rise) next_state = pulse_valid ?
                    sfr_pkg::SFR_ST_RECOVER : sfr_pkg::SFR_ST_READY;
            sfr_pkg::SFR_ST_RECOVER:
                if (timer_done) next_state = sfr_pkg::SFR_ST_READY;
            sfr_pkg::SFR_ST_READONLY:
                if (timer_done) next_state = sfr_pkg::SFR_ST_READY;
            sfr_pkg::SFR_ST_READY:
                next_state = state;
            default:
                next_state = sfr_pkg::SFR_ST_POR;
        endcase
        if (!supply_ok_in) next_state = sfr_pkg::SFR_ST_POR;
        else if (pin_low && state != sfr_pkg::SFR_ST_POR)
            next_state = sfr_pkg::SFR_ST_RESET;
    end

    wire logic do_clear = (state == sfr_pkg::SFR_ST_RECOVER) ||
                          (state == sfr_pkg::SFR_ST_POR);
    wire logic in_ready = (next_state == sfr_pkg::SFR_ST_READY);
    wire logic in_read  = in_ready ||
                          (next_state == sfr_pkg::SFR_ST_READONLY);
    wire logic idle_ok  = select_n_in;

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state <= sfr_pkg::SFR_ST_POR;
            op_at_reset <= sfr_pkg::SFR_OP_IDLE;
            low_count <= '0;
            pulse_valid <= 1'b0;
            pin_low_q <= 1'b0;
        end else begin
            state <= next_state;
            pin_low_q <= pin_low;
            low_count <= next_low_count;
            if (pin_low && !pin_low_q && state != sfr_pkg::SFR_ST_RESET)
                op_at_reset <= op_in;
            if (pin_low)
                pulse_valid <= (next_low_count >= W'(LOW_PULSE_CYC));
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            vol_out.write_enable_latch <= 1'b0;
            vol_out.write_in_progress <= 1'b0;
            vol_out.block_lock <= `SFR_LOCK_DEFAULT;
        end else if (do_clear || pin_low) begin
            vol_out.write_enable_latch <= 1'b0;
            vol_out.write_in_progress <= 1'b0;
            vol_out.block_lock <= `SFR_LOCK_DEFAULT;
        end else begin
            vol_out.write_enable_latch <= wel_set_in ||
                (vol_out.write_enable_latch && !wel_clr_in);
            vol_out.write_in_progress <= busy_op;
            vol_out.block_lock <= vol_out.block_lock || lock_set_in;
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cmd_accept_out <= 1'b0;
            write_accept_out <= 1'b0;
            abort_out <= 1'b0;
            data_oe_out <= 1'b0;
            standby_out <= 1'b1;
            stat_out <= '0;
        end else begin
            cmd_accept_out <= in_read && (idle_ok || cmd_accept_out);
            write_accept_out <= in_ready && (idle_ok || write_accept_out);
            abort_out <= pin_low && busy_op;
            data_oe_out <= in_read && !pin_low && !select_n_in;
            standby_out <= in_ready && select_n_in;
            stat_out.ready <= in_ready;
            stat_out.write_ok <= in_ready;
            stat_out.pulse_short <= pin_rise && !pulse_valid;
        end
    end
endmodule // sfr_reset_seq

// ===== sim/sfr_reset_seq_assertions.sv
`timescale 1ns/1ps
module sfr_reset_seq_chk #(
    parameter int LOW_PULSE_CYC = 100
) (
    // Clock, supply and host pins.
    input wire logic               ref_clk_in, arst_n_in, supply_ok_in,
    input wire logic               pin_reset_n_in, select_n_in,
    input wire sfr_pkg::sfr_op_e   op_in,
    // Outputs.
    input wire logic               cmd_accept_out, write_accept_out,
    input wire logic               abort_out, data_oe_out, standby_out,
    input wire sfr_pkg::sfr_vol_s  vol_out,
    input wire sfr_pkg::sfr_stat_s stat_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!arst_n_in);
    logic [7:0] low_cnt;
    wire        wop = (op_in >= sfr_pkg::SFR_OP_PROGRAM);
    always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) low_cnt <= 8'h00;
        else if (pin_reset_n_in) low_cnt <= 8'h00;
        else if (low_cnt != 8'hFF) low_cnt <= low_cnt + 8'h01;
    end
    oe_off_a: assert property (!pin_reset_n_in |=> !data_oe_out)
        else $error("data output enabled in reset");
    vol_clear_a: assert property (low_cnt > LOW_PULSE_CYC |->
        vol_out == 3'h1) else $error("volatile bits not at default");
    abort_op_a: assert property ((!pin_reset_n_in && wop)[*2]
        |-> abort_out) else $error("busy operation not aborted");
    rst_mute_a: assert property (low_cnt > LOW_PULSE_CYC |->
        !cmd_accept_out && !write_accept_out) else $error("accept in reset");
    wr_ready_a: assert property (write_accept_out |-> stat_out.ready)
        else $error("write accepted before ready");
    accept_desel_a: assert property ($rose(cmd_accept_out)
        |-> $past(select_n_in)) else $error("accept gained while selected");
    standby_a: assert property ((stat_out.ready && select_n_in)[*2]
        |-> standby_out) else $error("ready and idle but not standby");
    por_mute_a: assert property (!supply_ok_in |=> !cmd_accept_out)
        else $error("command accepted at power-on");
    cover property ($rose(stat_out.ready));
    cover property (abort_out);
    cover property (stat_out.pulse_short);
endmodule // sfr_reset_seq_chk
bind sfr_reset_seq sfr_reset_seq_chk #(.LOW_PULSE_CYC(LOW_PULSE_CYC)) i_chk (
    .ref_clk_in, .arst_n_in, .supply_ok_in, .pin_reset_n_in, .select_n_in,
    .op_in, .cmd_accept_out, .write_accept_out, .abort_out, .data_oe_out,
    .standby_out, .vol_out, .stat_out);

// ===== sim/sfr_host_model.sv
`timescale 1ns/1ps
`include "sfr_regs.svh"
module sfr_host_model #(
    parameter int WAIT_CYC = `SFR_US_TO_CYC(`SFR_SELECT_WAIT_US)
) (
    // Clock and test requests.
    input  wire logic       ref_clk_in, rst_req_in, sel_req_in,
    input  wire logic [7:0] rst_len_in,
    // Host pins.
    output logic            pin_reset_n_out,
    output logic            select_n_out
);
    logic [7:0] low_cnt = 8'h00;
    logic [7:0] gap_cnt = 8'h00;
    initial pin_reset_n_out = 1'b1;
    // Reset is held for exactly the requested length.
    always @(negedge ref_clk_in) begin
        if (low_cnt != 8'h00) begin
            low_cnt <= low_cnt - 8'h01;
            if (low_cnt == 8'h01) begin
                pin_reset_n_out <= 1'b1;
                gap_cnt         <= WAIT_CYC[7:0];
            end
        end else if (rst_req_in) begin
            low_cnt         <= rst_len_in;
            pin_reset_n_out <= 1'b0;
        end else if (gap_cnt != 8'h00) gap_cnt <= gap_cnt - 8'h01;
    end
    assign select_n_out = !(sel_req_in && pin_reset_n_out
        && gap_cnt == 8'h00 && low_cnt == 8'h00);
endmodule // sfr_host_model

// ===== sim/serial_flash_reset_power_on_tb_top.sv
`timescale 1ns/1ps
`include "sfr_regs.svh"
module serial_flash_reset_power_on_tb_top;
    // Erase and status recoveries are shortened to keep the run brief.
    localparam int SECTOR_T = 18;
    localparam int BLOCK_T  = 20;
    localparam int CHIP_T   = 22;
    localparam int STATUS_T = 24;
    localparam int SETTLE_T = `SFR_US_TO_CYC(`SFR_SETTLE_US);
    logic ref_clk_in = 0, arst_n_in = 0, supply_ok_in = 0, rst_req = 0;
    logic sel_req = 0, wel_set_in = 0, wel_clr_in = 0, lock_set_in = 0;
    logic [7:0] rst_len = 8'h00;
    logic pin_n, sel_n, cmd_acc, wr_acc, abort_out, oe_out, stby;
    sfr_pkg::sfr_op_e   op_in = sfr_pkg::SFR_OP_IDLE;
    sfr_pkg::sfr_vol_s  vol;
    sfr_pkg::sfr_stat_s stat;
    int bad_count = 0, cmp_count = 0;
    always #50 ref_clk_in = ~ref_clk_in;
    sfr_host_model i_host (.ref_clk_in, .rst_req_in(rst_req),
        .sel_req_in(sel_req), .rst_len_in(rst_len),
        .pin_reset_n_out(pin_n), .select_n_out(sel_n));
    sfr_reset_seq #(.SECTOR_CYC(SECTOR_T), .BLOCK_CYC(BLOCK_T),
        .CHIP_CYC(CHIP_T), .STATUS_CYC(STATUS_T)) i_dut (.ref_clk_in,
        .arst_n_in,
        .supply_ok_in, .pin_reset_n_in(pin_n), .select_n_in(sel_n), .op_in,
        .wel_set_in, .wel_clr_in, .lock_set_in, .cmd_accept_out(cmd_acc),
        .write_accept_out(wr_acc), .abort_out, .data_oe_out(oe_out),
        .standby_out(stby), .vol_out(vol), .stat_out(stat));
    task chk(input logic [31:0] got, input int lo, input int hi);
        cmp_count++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%0h exp=%0h..%0h", $time, got, lo, hi);
        end
    endtask
    function automatic int exp_cyc(input int op);
        case (op)
            1:       return `SFR_US_TO_CYC(`SFR_DECODE_US);
            3:       return `SFR_US_TO_CYC(`SFR_PROGRAM_US);
            4:       return SECTOR_T;
            5:       return BLOCK_T;
            6:       return CHIP_T;
            7:       return STATUS_T;
            default: return `SFR_US_TO_CYC(`SFR_READ_US);
        endcase
    endfunction
    task wait_rdy(output int n, input logic sel);
        n = 0;
        sel_req <= sel;
        while (stat.ready !== 1'b1 && n < 4000) begin
            @(negedge ref_clk_in);
            n++;
            if (n == 8) begin
                if (sel) chk(cmd_acc, 0, 0);
                sel_req <= 1'b0;
            end
        end
        repeat (2) @(negedge ref_clk_in);
    endtask
    task pulse_rst(input logic [7:0] len);
        @(negedge ref_clk_in);
        rst_len <= len;
        rst_req <= 1'b1;
        @(negedge ref_clk_in);
        rst_req <= 1'b0;
    endtask
    task t_power;
        int n;
        repeat (20) @(negedge ref_clk_in);
        chk(cmd_acc, 0, 0);
        chk(vol, 1, 1);
        supply_ok_in <= 1'b1;
        wait_rdy(n, 1'b0);
        chk(n - 2, SETTLE_T, SETTLE_T);
        chk(wr_acc, 1, 1);
        chk(stby, 1, 1);
    endtask
    task t_ops;
        int n;
        for (int i = 0; i < 8; i++) begin
            op_in <= sfr_pkg::sfr_op_e'(i);
            @(negedge ref_clk_in) wel_set_in <= 1'b1;
            @(negedge ref_clk_in) wel_set_in <= 1'b0;
            chk(vol.write_enable_latch, 1, 1);
            pulse_rst(8'h70);
            repeat (9) @(negedge ref_clk_in);
            chk(abort_out, i >= 3, i >= 3);
            chk(oe_out, 0, 0);
            @(negedge ref_clk_in) op_in <= sfr_pkg::SFR_OP_IDLE;
            // Core strobes while reset is held must not move the bits.
            @(negedge ref_clk_in);
            wel_set_in  <= 1'b1;
            lock_set_in <= 1'b1;
            @(negedge ref_clk_in);
            wel_set_in  <= 1'b0;
            lock_set_in <= 1'b0;
            wel_clr_in  <= 1'b1;
            @(negedge ref_clk_in) wel_clr_in <= 1'b0;
            chk(vol, 1, 1);
            wait (pin_n === 1'b1);
            wait_rdy(n, 1'b1);
            chk(n - 2, exp_cyc(i), exp_cyc(i));
            chk(vol, 1, 1);
            chk(stby, 1, 1);
        end
    endtask
    task t_short;
        logic seen;
        seen = 1'b0;
        @(negedge ref_clk_in) wel_set_in <= 1'b1;
        @(negedge ref_clk_in) wel_set_in <= 1'b0;
        pulse_rst(8'h03);
        repeat (15) @(negedge ref_clk_in) seen |= stat.pulse_short;
        chk(seen, 1, 1);
        // A pulse below the minimum leaves no recovery time behind.
        chk(stat.ready, 1, 1);
    endtask
    task conclude;
        $display("compares=%0d mismatches=%0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (16) @(negedge ref_clk_in);
        arst_n_in <= 1'b1;
        t_power;
        t_ops;
        t_short;
        conclude;
    end
    initial begin
        repeat (20000) @(posedge ref_clk_in);
        bad_count++;
        conclude;
    end
endmodule // serial_flash_reset_power_on_tb_top
